//--- swe_consts.svh
// Constants shared by both ends of the single-wire EEPROM link
`ifndef SWE_CONSTS_SVH
`define SWE_CONSTS_SVH
`define SWE_CLK_KHZ 100000
`define SWE_PROG_MS 10
`define SWE_SLOT_CYC 3'h4
`define SWE_ROM_LEN 6'h3f
`define SWE_FAM_END 6'h08
`define SWE_SER_END 6'h38
`define SWE_MEM_BYTES 32
`define SWE_AR_BYTES 8
`define SWE_CRC_TAPS 8'h0c
`define SWE_CMD_READ_ROM 8'h33
`define SWE_CMD_MATCH_ROM 8'h55
`define SWE_CMD_SKIP_ROM 8'hcc
`define SWE_CMD_WR_SP 8'h0f
`define SWE_CMD_RD_SP 8'haa
`define SWE_CMD_COPY_SP 8'h55
`define SWE_CMD_RD_MEM 8'hf0
`define SWE_CMD_WR_AR 8'h99
`define SWE_CMD_RD_AR 8'hc3
`define SWE_CMD_LOCK_AR 8'h5a
`define SWE_CMD_RD_STAT 8'h66
`define SWE_KEY_COPY 8'ha5
`define SWE_KEY_STAT 8'h00
`define SWE_STAT_OPEN 8'hff
`define SWE_STAT_LOCKED 8'hfc
`endif

//--- swe_pkg.sv
// Types shared by both ends of the single-wire EEPROM link
package swe_pkg;
    typedef enum logic [3:0] {
        DS_IDLE, DS_ROMCMD, DS_ROMTX, DS_MATCH, DS_MEMCMD, DS_ADDR, DS_WRSP,
        DS_RDSP, DS_WRAR, DS_RDAR, DS_KEY, DS_STAT, DS_PROG
    } swe_dev_st_e;
    typedef enum logic [1:0] {HS_IDLE, HS_BIT, HS_WAIT} swe_host_st_e;
    typedef enum logic [1:0] {OP_RESET, OP_WRITE, OP_READ, OP_WAIT} swe_op_e;
    typedef logic [7:0] swe_byte_t;
endpackage

//--- swe_if.sv
// Wired-AND single-wire link between bus master and EEPROM
`timescale 1ns/1ns
interface swe_if;
    logic bus_rst;
    logic slot;
    logic m_pull;
    logic d_pull;
    logic line;
    // Open-drain line: high unless some party pulls it low
    assign line = ~(m_pull | d_pull);
    modport dev(input bus_rst, input slot, input line, output d_pull);
    modport host(output bus_rst, output slot, output m_pull, input line);
endinterface

//--- swe_crc8.sv
// Serial checksum generator, one bit per enable, shared by both ends
`timescale 1ns/1ns
`include "swe_consts.svh"
module swe_crc8
    import swe_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Control
    input wire logic clr_i,
    input wire logic en_i,
    input wire logic bit_i,
    // Result
    output swe_byte_t crc_o
);
    logic fb;
    swe_byte_t crc_ff;
    assign fb = crc_ff[0] ^ bit_i;
    assign crc_o = crc_ff;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            crc_ff <= 8'h00;
        end else if (clr_i) begin
            crc_ff <= 8'h00;
        end else if (en_i) begin
            crc_ff <= {fb, crc_ff[7:1]} ^ (fb ? `SWE_CRC_TAPS : 8'h00);
        end
    end
endmodule

//--- swe_dev.sv
// EEPROM slave end: ROM select, scratchpads, data memory, lockable register
`timescale 1ns/1ns
`include "swe_consts.svh"
module swe_dev
    import swe_pkg::*;
#(
    parameter int unsigned PROG_CYC = `SWE_PROG_MS * `SWE_CLK_KHZ,
    // Arbitrary identity values
    parameter logic [7:0] FAMILY = 8'h5c,
    parameter logic [47:0] SERIAL = 48'h0123_4567_89ab
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Link
    swe_if.dev bus,
    // Status
    output logic locked_o,
    output logic busy_o,
    output logic selected_o
);
    localparam int unsigned PW = $clog2(PROG_CYC + 1);

    swe_dev_st_e st_ff;
    logic [2:0] cnt_ff;
    swe_byte_t sh_ff;
    logic [5:0] idx_ff;
    swe_byte_t cmd_ff;
    logic [4:0] addr_ff;
    logic locked_ff;
    logic [PW-1:0] prog_ff;
    logic d_pull_ff;
    swe_byte_t mem_ff [`SWE_MEM_BYTES];
    swe_byte_t spad_ff [`SWE_MEM_BYTES];
    swe_byte_t ar_ff [`SWE_AR_BYTES];
    swe_byte_t arsp_ff [`SWE_AR_BYTES];
    swe_byte_t crc;
    swe_byte_t rx_byte;
    swe_byte_t stat;
    logic slot_ok;
    logic byte_end;
    logic crc_en;
    logic tx_bit;
    logic key_ok_copy;
    logic key_ok_lock;

    function automatic logic rom_bit(input logic [5:0] idx, input swe_byte_t c);
        logic b;
        b = 1'b0;
        if (idx < `SWE_FAM_END) begin
            b = FAMILY[idx[2:0]];
        end else if (idx < `SWE_SER_END) begin
            b = SERIAL[idx - `SWE_FAM_END];
        end else begin
            b = c[idx[2:0]];
        end
        return b;
    endfunction

    function automatic logic [4:0] nxt_ar_addr(input logic [4:0] a);
        return {2'b00, a[2:0] + 3'h1};
    endfunction

    // Bits arrive least significant first
    assign rx_byte = {bus.line, sh_ff[7:1]};
    assign slot_ok = bus.slot & ~bus.bus_rst;
    assign byte_end = slot_ok & (cnt_ff == 3'h7);
    assign stat = locked_ff ? `SWE_STAT_LOCKED : `SWE_STAT_OPEN;
    assign key_ok_copy = byte_end && st_ff == DS_KEY && cmd_ff == `SWE_CMD_COPY_SP
        && rx_byte == `SWE_KEY_COPY;
    assign key_ok_lock = byte_end && st_ff == DS_KEY && cmd_ff == `SWE_CMD_LOCK_AR
        && rx_byte == `SWE_KEY_COPY && !locked_ff;
    // Checksum is rebuilt from the identity bits as they go out or are matched
    assign crc_en = slot_ok && (st_ff == DS_ROMTX || st_ff == DS_MATCH) && idx_ff < `SWE_SER_END;

    swe_crc8 u_crc (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .clr_i(bus.bus_rst),
        .en_i(crc_en),
        .bit_i(rom_bit(idx_ff, crc)),
        .crc_o(crc)
    );

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_ff <= DS_IDLE;
            cnt_ff <= 3'h0;
            sh_ff <= 8'h00;
            idx_ff <= 6'h00;
            cmd_ff <= 8'h00;
            addr_ff <= 5'h00;
            prog_ff <= '0;
        end else if (bus.bus_rst && st_ff != DS_PROG) begin
            // A reset pulse ends any transfer, including one waiting for its key
            st_ff <= DS_ROMCMD;
            cnt_ff <= 3'h0;
            idx_ff <= 6'h00;
        end else if (st_ff == DS_PROG) begin
            // Programming runs to completion; the master keeps the line idle
            if (prog_ff == '0) begin
                st_ff <= DS_IDLE;
            end else begin
                prog_ff <= prog_ff - 1'b1;
            end
        end else if (bus.slot) begin
            cnt_ff <= cnt_ff + 3'h1;
            sh_ff <= rx_byte;
            unique case (st_ff)
                DS_ROMCMD: begin
                    if (byte_end) begin
                        unique case (rx_byte)
                            `SWE_CMD_READ_ROM: st_ff <= DS_ROMTX;
                            `SWE_CMD_MATCH_ROM: st_ff <= DS_MATCH;
                            `SWE_CMD_SKIP_ROM: st_ff <= DS_MEMCMD;
                            default: st_ff <= DS_IDLE;
                        endcase
                    end
                end
                DS_ROMTX: begin
                    idx_ff <= idx_ff + 6'h01;
                    if (idx_ff == `SWE_ROM_LEN) begin
                        st_ff <= DS_MEMCMD;
                    end
                end
                DS_MATCH: begin
                    idx_ff <= idx_ff + 6'h01;
                    if (bus.line != rom_bit(idx_ff, crc)) begin
                        st_ff <= DS_IDLE;
                    end else if (idx_ff == `SWE_ROM_LEN) begin
                        st_ff <= DS_MEMCMD;
                    end
                end
                DS_MEMCMD: begin
                    // Only reachable after a successful ROM select
                    if (byte_end) begin
                        cmd_ff <= rx_byte;
                        unique case (rx_byte)
                            `SWE_CMD_WR_SP, `SWE_CMD_RD_SP, `SWE_CMD_RD_MEM,
                            `SWE_CMD_WR_AR, `SWE_CMD_RD_AR: st_ff <= DS_ADDR;
                            `SWE_CMD_COPY_SP, `SWE_CMD_LOCK_AR, `SWE_CMD_RD_STAT: st_ff <= DS_KEY;
                            default: st_ff <= DS_IDLE;
                        endcase
                    end
                end
                DS_ADDR: begin
                    if (byte_end) begin
                        addr_ff <= rx_byte[4:0];
                        unique case (cmd_ff)
                            `SWE_CMD_WR_SP: st_ff <= DS_WRSP;
                            `SWE_CMD_WR_AR: st_ff <= DS_WRAR;
                            `SWE_CMD_RD_AR: st_ff <= DS_RDAR;
                            default: st_ff <= DS_RDSP;
                        endcase
                        if (cmd_ff == `SWE_CMD_WR_AR || cmd_ff == `SWE_CMD_RD_AR) begin
                            addr_ff <= {2'b00, rx_byte[2:0]};
                        end
                    end
                end
                DS_WRSP, DS_RDSP: begin
                    if (byte_end) begin
                        addr_ff <= addr_ff + 5'h01;
                    end
                end
                DS_WRAR, DS_RDAR: begin
                    if (byte_end) begin
                        addr_ff <= nxt_ar_addr(addr_ff);
                    end
                end
                DS_KEY: begin
                    if (byte_end) begin
                        if (cmd_ff == `SWE_CMD_RD_STAT && rx_byte == `SWE_KEY_STAT) begin
                            st_ff <= DS_STAT;
                        end else if (key_ok_copy || key_ok_lock) begin
                            st_ff <= DS_PROG;
                            prog_ff <= PW'(PROG_CYC - 1);
                        end else begin
                            st_ff <= DS_IDLE;
                        end
                    end
                end
                default: ;
            endcase
        end
    end

    // Storage; every write lands in a scratchpad first
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < `SWE_MEM_BYTES; i++) begin
                mem_ff[i] <= 8'h00;
                spad_ff[i] <= 8'h00;
            end
            for (int i = 0; i < `SWE_AR_BYTES; i++) begin
                ar_ff[i] <= 8'h00;
                arsp_ff[i] <= 8'h00;
            end
        end else begin
            if (byte_end && st_ff == DS_WRSP) begin
                spad_ff[addr_ff] <= rx_byte;
            end
            if (byte_end && st_ff == DS_WRAR && !locked_ff) begin
                arsp_ff[addr_ff[2:0]] <= rx_byte;
            end
            if (byte_end && st_ff == DS_MEMCMD && rx_byte == `SWE_CMD_RD_MEM) begin
                spad_ff <= mem_ff;
            end
            if (key_ok_copy) begin
                mem_ff <= spad_ff;
            end
            if (key_ok_lock) begin
                ar_ff <= arsp_ff;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            locked_ff <= 1'b0;
        end else if (key_ok_lock) begin
            locked_ff <= 1'b1;
        end
    end

    // Transmit bit; once locked the register scratchpad can no longer be read
    always_comb begin
        tx_bit = 1'b1;
        unique case (st_ff)
            DS_ROMTX: tx_bit = rom_bit(idx_ff, crc);
            DS_RDSP: tx_bit = spad_ff[addr_ff][cnt_ff];
            DS_RDAR: tx_bit = locked_ff ? ar_ff[addr_ff[2:0]][cnt_ff] : arsp_ff[addr_ff[2:0]][cnt_ff];
            DS_STAT: tx_bit = stat[cnt_ff];
            default: tx_bit = 1'b1;
        endcase
    end

    // Registered pull lags state by one cycle, so slots must be two cycles apart
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            d_pull_ff <= 1'b0;
        end else begin
            d_pull_ff <= ~tx_bit;
        end
    end

    assign bus.d_pull = d_pull_ff;
    assign locked_o = locked_ff;
    assign busy_o = (st_ff == DS_PROG);
    assign selected_o = (st_ff != DS_IDLE) && (st_ff != DS_ROMCMD) && (st_ff != DS_ROMTX)
        && (st_ff != DS_MATCH);
endmodule

//--- swe_host.sv
// Bus master end: byte slots, reset pulses, programming wait, identity check
`timescale 1ns/1ns
`include "swe_consts.svh"
module swe_host
    import swe_pkg::*;
#(
    parameter int unsigned PROG_CYC = `SWE_PROG_MS * `SWE_CLK_KHZ
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Link
    swe_if.host bus,
    // User request
    input wire logic req_i,
    input wire swe_op_e op_i,
    input wire swe_byte_t wdata_i,
    output logic ready_o,
    // User answer
    output logic done_o,
    output swe_byte_t rdata_o,
    output logic crc_ok_o
);
    localparam int unsigned PW = $clog2(PROG_CYC + 1);

    swe_host_st_e st_ff;
    logic [2:0] tcnt_ff;
    logic [2:0] bit_ff;
    swe_byte_t sh_ff;
    logic wr_ff;
    logic m_pull_ff;
    logic slot_ff;
    logic rst_ff;
    logic done_ff;
    swe_byte_t rdata_ff;
    logic [PW-1:0] wait_ff;
    swe_byte_t crc;

    swe_crc8 u_crc (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .clr_i(rst_ff),
        .en_i(slot_ff & ~wr_ff),
        .bit_i(bus.line),
        .crc_o(crc)
    );

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_ff <= HS_IDLE;
            tcnt_ff <= 3'h0;
            bit_ff <= 3'h0;
            sh_ff <= 8'h00;
            wr_ff <= 1'b0;
            m_pull_ff <= 1'b0;
            slot_ff <= 1'b0;
            rst_ff <= 1'b0;
            done_ff <= 1'b0;
            rdata_ff <= 8'h00;
            wait_ff <= '0;
        end else begin
            rst_ff <= 1'b0;
            done_ff <= 1'b0;
            slot_ff <= 1'b0;
            unique case (st_ff)
                HS_IDLE: begin
                    if (req_i) begin
                        unique case (op_i)
                            OP_RESET: begin
                                rst_ff <= 1'b1;
                                done_ff <= 1'b1;
                            end
                            OP_WAIT: begin
                                st_ff <= HS_WAIT;
                                wait_ff <= PW'(PROG_CYC - 1);
                            end
                            default: begin
                                st_ff <= HS_BIT;
                                wr_ff <= (op_i == OP_WRITE);
                                sh_ff <= wdata_i;
                                m_pull_ff <= (op_i == OP_WRITE) & ~wdata_i[0];
                                tcnt_ff <= 3'h0;
                                bit_ff <= 3'h0;
                            end
                        endcase
                    end
                end
                HS_BIT: begin
                    tcnt_ff <= tcnt_ff + 3'h1;
                    slot_ff <= (tcnt_ff == `SWE_SLOT_CYC - 3'h2);
                    if (slot_ff) begin
                        tcnt_ff <= 3'h0;
                        bit_ff <= bit_ff + 3'h1;
                        sh_ff <= {bus.line, sh_ff[7:1]};
                        m_pull_ff <= wr_ff & ~sh_ff[1] & (bit_ff != 3'h7);
                        if (bit_ff == 3'h7) begin
                            st_ff <= HS_IDLE;
                            done_ff <= 1'b1;
                            rdata_ff <= {bus.line, sh_ff[7:1]};
                        end
                    end
                end
                HS_WAIT: begin
                    // Line stays released so the device can program
                    if (wait_ff == '0) begin
                        st_ff <= HS_IDLE;
                        done_ff <= 1'b1;
                    end else begin
                        wait_ff <= wait_ff - 1'b1;
                    end
                end
                default: st_ff <= HS_IDLE;
            endcase
        end
    end

    assign bus.bus_rst = rst_ff;
    assign bus.slot = slot_ff;
    assign bus.m_pull = m_pull_ff;
    assign ready_o = (st_ff == HS_IDLE) & ~rst_ff;
    assign done_o = done_ff;
    assign rdata_o = rdata_ff;
    // Zero after reading the whole identity means it arrived intact
    assign crc_ok_o = (crc == 8'h00);
endmodule

//--- swe_eeprom_checker.sv
// Protocol checks on the single-wire link between the two ends
`timescale 1ns/1ns
module swe_eeprom_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Link
    input wire logic bus_rst,
    input wire logic slot,
    input wire logic m_pull,
    input wire logic d_pull,
    input wire logic line
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    // A strobe is followed by three quiet cycles before the next bit
    sequence s_gap;
        !slot [*3];
    endsequence

    // After a reset pulse neither party holds the line low
    sequence s_rst_clear;
        !m_pull ##2 !d_pull;
    endsequence

    AST_SLOT_GAP: assert property (slot |=> s_gap)
        else $error("sample strobes closer than four cycles");
    AST_RST_PULSE: assert property (bus_rst |=> !bus_rst)
        else $error("reset pulse longer than one cycle");
    AST_RST_NO_SLOT: assert property (bus_rst |-> !slot)
        else $error("reset pulse and sample strobe together");
    AST_RST_RELEASE: assert property (bus_rst |-> s_rst_clear)
        else $error("line still pulled after reset pulse");
    AST_MPULL_HELD: assert property (slot |-> $stable(m_pull))
        else $error("master level moved at sample strobe");
    AST_DPULL_HELD: assert property (slot |-> $stable(d_pull))
        else $error("device level moved at sample strobe");
    AST_MPULL_FRAMED: assert property (m_pull |-> ##[0:3] slot)
        else $error("master pulls line outside a bit");
    // Both ends driving at once means they disagree on who owns the bit
    AST_NO_CLASH: assert property (d_pull |-> !m_pull && !line)
        else $error("master and device drive the line together");
endmodule

//--- single_wire_eeprom_memory_tb.sv
// Self-checking bench: host and device joined over the single-wire link
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module single_wire_eeprom_memory_tb;
    import swe_pkg::*;
    // Short programming wait keeps the run brief
    localparam int PROG = 20;
    // Arbitrary identity values
    localparam logic [7:0] FAM = 8'h3a;
    localparam logic [47:0] SER = 48'hc0de_1234_5a5a;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic req = 1'b0;
    swe_op_e op = OP_RESET;
    swe_byte_t wdata = 8'h00;
    logic ready, done, crc_ok, locked, busy, sel;
    swe_byte_t rdata, rd, cap;
    swe_byte_t sp [32];
    swe_byte_t mem [32];
    swe_byte_t ar [8];
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;

    swe_if bus();
    swe_dev #(.PROG_CYC(PROG), .FAMILY(FAM), .SERIAL(SER)) swe_dev_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .bus(bus), .locked_o(locked), .busy_o(busy), .selected_o(sel));
    swe_host #(.PROG_CYC(PROG)) swe_host_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus(bus), .req_i(req),
        .op_i(op), .wdata_i(wdata), .ready_o(ready), .done_o(done), .rdata_o(rdata), .crc_ok_o(crc_ok));
    swe_eeprom_checker swe_eeprom_checker_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus_rst(bus.bus_rst),
        .slot(bus.slot), .m_pull(bus.m_pull), .d_pull(bus.d_pull), .line(bus.line));

    always #5 clk_i = ~clk_i;

    // Rebuild each byte from the wire itself, first bit into the low end
    always @(posedge clk_i) if (bus.slot) cap <= {bus.line, cap[7:1]};

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            $display("[ERR] cycles exp below %0d got %0d", 30000, cyc);
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    function automatic swe_byte_t crc_of(input logic [55:0] v);
        swe_byte_t c;
        logic fb;
        c = 8'h00;
        for (int i = 0; i < 56; i++) begin
            fb = c[0] ^ v[i];
            c = c >> 1;
            if (fb) c = c ^ 8'h8c;
        end
        return c;
    endfunction

    // One user operation; inputs change only at falling edges
    task automatic tx(input swe_op_e o, input swe_byte_t d);
        int i;
        for (i = 0; i < 1000 && ready !== 1'b1; i++) @(negedge clk_i);
        op = o;
        wdata = d;
        req = 1'b1;
        @(negedge clk_i);
        req = 1'b0;
        for (i = 0; i < PROG + 100 && done !== 1'b1; i++) @(negedge clk_i);
        `CHK("done", 1'b1, done)
        rd = rdata;
        if (o == OP_WRITE || o == OP_READ) `CHK("wire byte", (o == OP_WRITE) ? d : rd, cap)
        @(negedge clk_i);
    endtask

    task automatic wb(input swe_byte_t b);
        tx(OP_WRITE, b);
    endtask

    task automatic rb();
        tx(OP_READ, 8'hff);
    endtask

    task automatic start(input swe_byte_t c);
        tx(OP_RESET, 8'h00);
        wb(8'hcc);
        wb(c);
    endtask

    initial begin
        swe_byte_t a;
        logic [63:0] id;
        void'($urandom(32'hebd5));
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (16) @(negedge clk_i);
        arst_n_i = 1'b1;

        id = {crc_of({SER, FAM}), SER, FAM};
        tx(OP_RESET, 8'h00);
        wb(8'h33);
        for (int i = 0; i < 8; i++) begin
            rb();
            `CHK("id byte", id[8*i +: 8], rd)
        end
        `CHK("checksum", crc_of({SER, FAM}), rd)
        `CHK("crc residue", 1'b1, crc_ok)
        $display("test identity read done");

        // Second pass spoils one serial byte, so the device must stay deaf
        for (int k = 0; k < 2; k++) begin
            tx(OP_RESET, 8'h00);
            wb(8'h55);
            for (int i = 0; i < 8; i++) wb(id[8*i +: 8] ^ ((k == 1 && i == 3) ? 8'h10 : 8'h00));
            wb(8'h66);
            wb(8'h00);
            rb();
            `CHK("selected", (k == 0) ? 1'b1 : 1'b0, sel)
            `CHK("status", 8'hff, rd)
        end
        $display("test select and status done");

        a = 8'($urandom_range(0, 31));
        start(8'h0f);
        wb(a);
        for (int i = 0; i < 34; i++) begin
            sp[(a + i) % 32] = 8'($urandom);
            wb(sp[(a + i) % 32]);
        end
        start(8'haa);
        wb(8'h1f);
        for (int i = 0; i < 33; i++) begin
            rb();
            `CHK("scratch read", sp[(31 + i) % 32], rd)
        end
        $display("test scratchpad wrap done");

        // Wrong key, then a reset in place of the key: memory must not change
        start(8'h55);
        wb(8'ha4);
        start(8'h55);
        start(8'hf0);
        wb(8'h00);
        for (int i = 0; i < 32; i++) begin
            rb();
            `CHK("memory kept", mem[i], rd)
        end
        start(8'h0f);
        wb(8'h00);
        for (int i = 0; i < 32; i++) begin
            mem[i] = 8'($urandom);
            wb(mem[i]);
        end
        start(8'h55);
        wb(8'ha5);
        `CHK("busy", 1'b1, busy)
        tx(OP_WAIT, 8'h00);
        start(8'h0f);
        wb(8'h05);
        wb(~mem[5]);
        start(8'hf0);
        wb(8'h00);
        for (int i = 0; i < 32; i++) begin
            rb();
            `CHK("memory copy", mem[i], rd)
        end
        start(8'haa);
        wb(8'h05);
        rb();
        `CHK("reloaded scratch", mem[5], rd)
        // Scratchpad now mirrors memory, so changing one byte keeps the rest
        mem[9] = 8'($urandom);
        start(8'h0f);
        wb(8'h09);
        wb(mem[9]);
        start(8'h55);
        wb(8'ha5);
        tx(OP_WAIT, 8'h00);
        start(8'hf0);
        wb(8'h00);
        for (int i = 0; i < 32; i++) begin
            rb();
            `CHK("partial copy", mem[i], rd)
        end
        $display("test copy done");

        start(8'h99);
        wb(8'h06);
        for (int i = 0; i < 3; i++) begin
            ar[(6 + i) % 8] = 8'($urandom);
            wb(ar[(6 + i) % 8]);
        end
        start(8'hc3);
        wb(8'h06);
        for (int i = 0; i < 3; i++) begin
            rb();
            `CHK("register scratch", ar[(6 + i) % 8], rd)
        end
        start(8'h5a);
        wb(8'ha5);
        tx(OP_WAIT, 8'h00);
        `CHK("locked", 1'b1, locked)
        start(8'h66);
        wb(8'h00);
        rb();
        `CHK("status locked", 8'hfc, rd)
        start(8'h99);
        wb(8'h06);
        wb(~ar[6]);
        start(8'h5a);
        wb(8'ha5);
        `CHK("relock refused", 1'b0, busy)
        tx(OP_WAIT, 8'h00);
        start(8'hc3);
        wb(8'h06);
        rb();
        `CHK("register protected", ar[6], rd)
        $display("test register lock done");
        complete_run();
    end
endmodule
